// *** pin_routing_pkg.sv ***
`default_nettype none

package pin_routing_pkg;

  // Crossbar dimensions
  localparam int SEL_W = 4;
  localparam int NUM_IN = 24;
  localparam int NUM_PINS = 32;
  localparam int GROUP_PINS = 8;
  localparam int NUM_GROUPS = 4;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 5;

  // Register map, byte addresses
  localparam logic [9:0] IN_SEL_BASE = 10'h000;
  localparam logic [9:0] OUT_SEL_BASE = 10'h100;
  localparam logic [9:0] CTRL_OFS = 10'h200;

  // Control register fields
  localparam int LOCK_BIT = 13;
  localparam int ONE_WAY_BIT = 29;

  // Reset values
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] NULL_CODE = 4'h0;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Input select register indices, word offset from IN_SEL_BASE
  localparam int EXT_IRQ4_PIN_SEL_IDX = 0;
  localparam int TIMER2_CLK_PIN_SEL_IDX = 1;
  localparam int CAPTURE4_PIN_SEL_IDX = 2;
  localparam int SPI1_SELECT_PIN_SEL_IDX = 3;
  localparam int REFCLK_IN_PIN_SEL_IDX = 4;
  localparam int EXT_IRQ3_PIN_SEL_IDX = 5;
  localparam int TIMER3_CLK_PIN_SEL_IDX = 6;
  localparam int CAPTURE3_PIN_SEL_IDX = 7;
  localparam int UART1_CLEAR_TO_SEND_PIN_SEL_IDX = 8;
  localparam int UART2_RECEIVE_PIN_SEL_IDX = 9;
  localparam int SPI1_DATA_IN_PIN_SEL_IDX = 10;
  localparam int EXT_IRQ2_PIN_SEL_IDX = 11;
  localparam int TIMER4_CLK_PIN_SEL_IDX = 12;
  localparam int CAPTURE1_PIN_SEL_IDX = 13;
  localparam int CAPTURE5_PIN_SEL_IDX = 14;
  localparam int UART1_RECEIVE_PIN_SEL_IDX = 15;
  localparam int UART2_CLEAR_TO_SEND_PIN_SEL_IDX = 16;
  localparam int SPI2_DATA_IN_PIN_SEL_IDX = 17;
  localparam int COMPARE_FAULT_B_PIN_SEL_IDX = 18;
  localparam int EXT_IRQ1_PIN_SEL_IDX = 19;
  localparam int TIMER5_CLK_PIN_SEL_IDX = 20;
  localparam int CAPTURE2_PIN_SEL_IDX = 21;
  localparam int SPI2_SELECT_PIN_SEL_IDX = 22;
  localparam int COMPARE_FAULT_A_PIN_SEL_IDX = 23;

  // Output codes that name a real source, one bit per code, per pin group
  localparam logic [7:0] OUT_CODE_VALID_A = 8'hae;
  localparam logic [7:0] OUT_CODE_VALID_B = 8'hb8;
  localparam logic [7:0] OUT_CODE_VALID_C = 8'hf8;
  localparam logic [7:0] OUT_CODE_VALID_D = 8'hb6;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_IN = 2'b01,
    KIND_OUT = 2'b11,
    KIND_CTRL = 2'b10
  } reg_kind_t;

  // Pin group that feeds a given peripheral input
  function automatic int in_group(input int idx);
    if (idx >= EXT_IRQ1_PIN_SEL_IDX) return 3;
    else if (idx >= EXT_IRQ2_PIN_SEL_IDX) return 2;
    else if (idx >= EXT_IRQ3_PIN_SEL_IDX) return 1;
    else return 0;
  endfunction

  // Codes with the top bit set select no pin
  function automatic logic code_reserved(input logic [3:0] code);
    return code[3];
  endfunction

  function automatic logic out_code_valid(input int grp, input logic [3:0] code);
    logic [7:0] mask;
    mask = (grp == 0) ? OUT_CODE_VALID_A : (grp == 1) ? OUT_CODE_VALID_B :
           (grp == 2) ? OUT_CODE_VALID_C : OUT_CODE_VALID_D;
    return !code[3] && mask[code[2:0]];
  endfunction

  // Address decode shared by the read and write paths
  function automatic reg_kind_t addr_kind(input logic [9:0] addr);
    if (addr[1:0] != 2'b00) return KIND_NONE;
    else if (addr >= IN_SEL_BASE && addr < IN_SEL_BASE + 10'(NUM_IN * 4)) return KIND_IN;
    else if (addr >= OUT_SEL_BASE && addr < OUT_SEL_BASE + 10'(NUM_PINS * 4)) return KIND_OUT;
    else if (addr == CTRL_OFS) return KIND_CTRL;
    else return KIND_NONE;
  endfunction

endpackage

`default_nettype wire

// *** route_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// Select fields handed from the register file to the two routers
interface route_if;
  logic [pin_routing_pkg::NUM_IN-1:0][pin_routing_pkg::SEL_W-1:0] in_sel;
  logic [pin_routing_pkg::NUM_PINS-1:0][pin_routing_pkg::SEL_W-1:0] out_sel;
  modport cfg (output in_sel, output out_sel);
  modport route (input in_sel, input out_sel);
endinterface

`default_nettype wire

// *** input_router.sv ***
`timescale 1ns/100ps
`default_nettype none

module input_router (
  // Select fields
  route_if.route sel,
  // Pad side
  input wire logic [pin_routing_pkg::NUM_PINS-1:0] pin_level,
  // Peripheral side
  output logic [pin_routing_pkg::NUM_IN-1:0] periph_level
);

  // One mux per peripheral input, drawing only from its own pin group
  always_comb begin
    for (int i = 0; i < pin_routing_pkg::NUM_IN; i++) begin
      if (pin_routing_pkg::code_reserved(sel.in_sel[i])) begin
        periph_level[i] = 1'b0; // RULE14
      end else begin
        periph_level[i] = pin_level[pin_routing_pkg::in_group(i) * pin_routing_pkg::GROUP_PINS
                                    + int'(sel.in_sel[i][2:0])]; // RULE2
      end
    end
  end

endmodule

`default_nettype wire

// *** output_router.sv ***
`timescale 1ns/100ps
`default_nettype none

module output_router (
  // Select fields
  route_if.route sel,
  // Peripheral sources, indexed by output code within each group
  input wire logic [pin_routing_pkg::NUM_GROUPS-1:0][7:0] src_grp,
  input wire logic [pin_routing_pkg::NUM_PINS-1:0] pin_analog,
  // Pad side
  output logic [pin_routing_pkg::NUM_PINS-1:0] drive_level,
  output logic [pin_routing_pkg::NUM_PINS-1:0] drive_en
);

  // Null and reserved codes leave the pad to its other functions
  always_comb begin
    for (int p = 0; p < pin_routing_pkg::NUM_PINS; p++) begin
      if (pin_routing_pkg::out_code_valid(p / pin_routing_pkg::GROUP_PINS, sel.out_sel[p])) begin
        drive_level[p] = src_grp[p / pin_routing_pkg::GROUP_PINS][sel.out_sel[p][2:0]]; // RULE9
        drive_en[p] = !pin_analog[p]; // RULE13
      end else begin
        drive_level[p] = 1'b0; // RULE10
        drive_en[p] = 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// *** remappable_pin_select.sv ***
// Summary of operation
// RULE1: Input and output routing use separate registers.
// RULE2: Each peripheral input owns its pin select.
// RULE3: Four-bit input code picks the matching pin.
// RULE4: First group codes select pins; 1000+ reserved.
// RULE5: Second group codes 0000-0111 pick pins.
// RULE6: Third group codes 0000-0111 pick pins.
// RULE7: Fourth group codes 0000-0111 pick pins.
// RULE8: Each pin owns its output source select.
// RULE9: Four-bit output code picks driving peripheral.
// RULE10: Output selects reset to null, nothing driven.
// RULE11: Lock set makes select writes silently ignored.
// RULE12: One-way option keeps lock until reset.
// RULE13: Routed peripheral beats digital, never analog.
// RULE14: Reserved input code gives constant low.
// RULE15: Select reads return field, upper bits zero.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module remappable_pin_select (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [pin_routing_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pin_routing_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pin_routing_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Lock configuration
  input wire logic one_way_lock_option,
  output logic routing_lock_bit,
  // Remappable pads
  input wire logic [pin_routing_pkg::NUM_PINS-1:0] remappable_pin_in,
  input wire logic [pin_routing_pkg::NUM_PINS-1:0] remappable_pin_analog,
  output logic [pin_routing_pkg::NUM_PINS-1:0] remappable_pin_out,
  output logic [pin_routing_pkg::NUM_PINS-1:0] remappable_pin_oe,
  // Peripheral outputs to route onto pins
  input wire logic uart1_tx,
  input wire logic uart2_rts,
  input wire logic spi1_select_out,
  input wire logic compare1_out,
  input wire logic comparator2_out,
  input wire logic spi1_data_out,
  input wire logic spi2_data_out,
  input wire logic compare2_out,
  input wire logic comparator3_out,
  input wire logic compare4_out,
  input wire logic compare5_out,
  input wire logic ref_clock_out,
  input wire logic uart1_rts,
  input wire logic uart2_tx,
  input wire logic spi2_select_out,
  input wire logic compare3_out,
  input wire logic comparator1_out,
  // Peripheral inputs fed from pins
  output logic ext_irq4_input,
  output logic timer2_clock_input,
  output logic capture4_input,
  output logic spi1_slave_select_input,
  output logic reference_clock_input,
  output logic ext_irq3_input,
  output logic timer3_clock_input,
  output logic capture3_input,
  output logic uart1_clear_to_send_input,
  output logic uart2_receive_input,
  output logic spi1_data_input,
  output logic ext_irq2_input,
  output logic timer4_clock_input,
  output logic capture1_input,
  output logic capture5_input,
  output logic uart1_receive_input,
  output logic uart2_clear_to_send_input,
  output logic spi2_data_input,
  output logic compare_fault_b_input,
  output logic ext_irq1_input,
  output logic timer5_clock_input,
  output logic capture2_input,
  output logic spi2_slave_select_input,
  output logic compare_fault_a_input
);

  localparam int NUM_IN = pin_routing_pkg::NUM_IN;
  localparam int NUM_PINS = pin_routing_pkg::NUM_PINS;
  localparam int SEL_W = pin_routing_pkg::SEL_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake and decode

  logic avs_waitrequest_reg;
  logic [pin_routing_pkg::DATA_W-1:0] avs_readdata_reg;
  logic lock_reg;
  logic [NUM_IN-1:0][SEL_W-1:0] in_sel_reg;
  logic [NUM_PINS-1:0][SEL_W-1:0] out_sel_reg;
  logic [NUM_IN-1:0] periph_in_reg;
  logic [NUM_PINS-1:0] pin_out_reg;
  logic [NUM_PINS-1:0] pin_oe_reg;
  logic [NUM_IN-1:0] periph_in_next;
  logic [NUM_PINS-1:0] pin_out_next;
  logic [NUM_PINS-1:0] pin_oe_next;
  pin_routing_pkg::reg_kind_t acc_kind;
  logic [pin_routing_pkg::IDX_W-1:0] acc_idx;
  logic bus_req;
  logic bus_take;
  logic bus_commit;
  logic in_wr;
  logic out_wr;
  logic ctrl_wr;
  logic [pin_routing_pkg::DATA_W-1:0] ctrl_rdata;
  logic [pin_routing_pkg::NUM_GROUPS-1:0][7:0] src_grp;

  // Word index within a select bank
  assign acc_kind = pin_routing_pkg::addr_kind(avs_address);
  assign acc_idx = avs_address[pin_routing_pkg::IDX_LSB +: pin_routing_pkg::IDX_W];
  assign bus_req = avs_read || avs_write;
  // Take on the first edge, commit on the edge where waitrequest is seen low
  assign bus_take = bus_req && avs_waitrequest_reg;
  assign bus_commit = bus_req && !avs_waitrequest_reg;
  assign in_wr = bus_commit && avs_write && acc_kind == pin_routing_pkg::KIND_IN;
  assign out_wr = bus_commit && avs_write && acc_kind == pin_routing_pkg::KIND_OUT;
  assign ctrl_wr = bus_commit && avs_write && acc_kind == pin_routing_pkg::KIND_CTRL;

  // Waitrequest drops for exactly one cycle per access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_reg <= 1'b1;
    end else if (bus_take) begin
      avs_waitrequest_reg <= 1'b0;
    end else begin
      avs_waitrequest_reg <= 1'b1;
    end
  end

  // Control readback: lock state and the one-way option level
  always_comb begin
    ctrl_rdata = '0;
    ctrl_rdata[pin_routing_pkg::LOCK_BIT] = lock_reg;
    ctrl_rdata[pin_routing_pkg::ONE_WAY_BIT] = one_way_lock_option;
  end

  // Read data captured at take, so it stands when waitrequest is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_reg <= pin_routing_pkg::RDATA_RESET;
    end else if (bus_take && avs_read) begin
      if (acc_kind == pin_routing_pkg::KIND_IN) begin
        avs_readdata_reg <= {28'h0000000, in_sel_reg[acc_idx]}; // RULE15
      end else if (acc_kind == pin_routing_pkg::KIND_OUT) begin
        avs_readdata_reg <= {28'h0000000, out_sel_reg[acc_idx]}; // RULE15
      end else if (acc_kind == pin_routing_pkg::KIND_CTRL) begin
        avs_readdata_reg <= ctrl_rdata;
      end else begin
        avs_readdata_reg <= pin_routing_pkg::RDATA_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lock and select registers

  // Setting always allowed; clearing refused while the one-way option holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= pin_routing_pkg::LOCK_RESET;
    end else if (ctrl_wr && avs_byteenable[1]) begin
      if (avs_writedata[pin_routing_pkg::LOCK_BIT]) begin
        lock_reg <= 1'b1;
      end else if (!one_way_lock_option) begin
        lock_reg <= 1'b0; // RULE12
      end
    end
  end

  // Input bank, one field per peripheral input; locked writes still complete
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_sel_reg <= {NUM_IN{pin_routing_pkg::SEL_RESET}};
    end else if (in_wr && avs_byteenable[0] && !lock_reg) begin // RULE11
      in_sel_reg[acc_idx] <= avs_writedata[SEL_W-1:0]; // RULE3
    end
  end

  // Output bank, one field per pin, kept apart from the input bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sel_reg <= {NUM_PINS{pin_routing_pkg::NULL_CODE}}; // RULE10
    end else if (out_wr && avs_byteenable[0] && !lock_reg) begin // RULE11
      out_sel_reg[acc_idx] <= avs_writedata[SEL_W-1:0]; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Routing

  route_if rif ();

  // Two separate banks feed two separate routers
  always_comb begin
    rif.in_sel = in_sel_reg; // RULE1
    rif.out_sel = out_sel_reg;
  end

  // Sources by code 7 down to 0; zeros stand for null and reserved codes
  assign src_grp[0] = {comparator2_out, 1'b0, compare1_out, 1'b0,
                       spi1_select_out, uart2_rts, uart1_tx, 1'b0};
  assign src_grp[1] = {comparator3_out, 1'b0, compare2_out, spi2_data_out,
                       spi1_data_out, 1'b0, 1'b0, 1'b0};
  assign src_grp[2] = {ref_clock_out, compare5_out, compare4_out, spi2_data_out,
                       spi1_data_out, 1'b0, 1'b0, 1'b0};
  assign src_grp[3] = {comparator1_out, 1'b0, compare3_out, spi2_select_out,
                       1'b0, uart2_tx, uart1_rts, 1'b0};

  // Analog pins read low to the digital side
  input_router u_input_router (
    .sel(rif.route),
    .pin_level(remappable_pin_in & ~remappable_pin_analog),
    .periph_level(periph_in_next)
  );

  output_router u_output_router (
    .sel(rif.route),
    .src_grp(src_grp),
    .pin_analog(remappable_pin_analog),
    .drive_level(pin_out_next),
    .drive_en(pin_oe_next)
  );

  // Registered routing adds one cycle of latency to every path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_in_reg <= '0;
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
    end else begin
      periph_in_reg <= periph_in_next; // RULE4 RULE5 RULE6 RULE7
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next; // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata = avs_readdata_reg;
  assign avs_waitrequest = avs_waitrequest_reg;
  assign routing_lock_bit = lock_reg;
  assign remappable_pin_out = pin_out_reg;
  assign remappable_pin_oe = pin_oe_reg;
  assign ext_irq4_input = periph_in_reg[pin_routing_pkg::EXT_IRQ4_PIN_SEL_IDX];
  assign timer2_clock_input = periph_in_reg[pin_routing_pkg::TIMER2_CLK_PIN_SEL_IDX];
  assign capture4_input = periph_in_reg[pin_routing_pkg::CAPTURE4_PIN_SEL_IDX];
  assign spi1_slave_select_input = periph_in_reg[pin_routing_pkg::SPI1_SELECT_PIN_SEL_IDX];
  assign reference_clock_input = periph_in_reg[pin_routing_pkg::REFCLK_IN_PIN_SEL_IDX];
  assign ext_irq3_input = periph_in_reg[pin_routing_pkg::EXT_IRQ3_PIN_SEL_IDX];
  assign timer3_clock_input = periph_in_reg[pin_routing_pkg::TIMER3_CLK_PIN_SEL_IDX];
  assign capture3_input = periph_in_reg[pin_routing_pkg::CAPTURE3_PIN_SEL_IDX];
  assign uart1_clear_to_send_input =
    periph_in_reg[pin_routing_pkg::UART1_CLEAR_TO_SEND_PIN_SEL_IDX];
  assign uart2_receive_input = periph_in_reg[pin_routing_pkg::UART2_RECEIVE_PIN_SEL_IDX];
  assign spi1_data_input = periph_in_reg[pin_routing_pkg::SPI1_DATA_IN_PIN_SEL_IDX];
  assign ext_irq2_input = periph_in_reg[pin_routing_pkg::EXT_IRQ2_PIN_SEL_IDX];
  assign timer4_clock_input = periph_in_reg[pin_routing_pkg::TIMER4_CLK_PIN_SEL_IDX];
  assign capture1_input = periph_in_reg[pin_routing_pkg::CAPTURE1_PIN_SEL_IDX];
  assign capture5_input = periph_in_reg[pin_routing_pkg::CAPTURE5_PIN_SEL_IDX];
  assign uart1_receive_input = periph_in_reg[pin_routing_pkg::UART1_RECEIVE_PIN_SEL_IDX];
  assign uart2_clear_to_send_input =
    periph_in_reg[pin_routing_pkg::UART2_CLEAR_TO_SEND_PIN_SEL_IDX];
  assign spi2_data_input = periph_in_reg[pin_routing_pkg::SPI2_DATA_IN_PIN_SEL_IDX];
  assign compare_fault_b_input = periph_in_reg[pin_routing_pkg::COMPARE_FAULT_B_PIN_SEL_IDX];
  assign ext_irq1_input = periph_in_reg[pin_routing_pkg::EXT_IRQ1_PIN_SEL_IDX];
  assign timer5_clock_input = periph_in_reg[pin_routing_pkg::TIMER5_CLK_PIN_SEL_IDX];
  assign capture2_input = periph_in_reg[pin_routing_pkg::CAPTURE2_PIN_SEL_IDX];
  assign spi2_slave_select_input = periph_in_reg[pin_routing_pkg::SPI2_SELECT_PIN_SEL_IDX];
  assign compare_fault_a_input = periph_in_reg[pin_routing_pkg::COMPARE_FAULT_A_PIN_SEL_IDX];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Bus answers one cycle after the request is seen
  AST_WAIT_ONE: assert property (bus_take |=> !avs_waitrequest_reg)
    else $error("waitrequest did not drop one cycle after a request");

  AST_LOCK_HOLDS_IN: assert property ( // RULE11
    in_wr && lock_reg |=> $stable(in_sel_reg))
    else $error("input select changed while locked");

  AST_LOCK_HOLDS_OUT: assert property ( // RULE11
    out_wr && lock_reg |=> $stable(out_sel_reg))
    else $error("output select changed while locked");

  AST_WRITE_TAKES: assert property ( // RULE3
    in_wr && !lock_reg && avs_byteenable[0]
    |=> in_sel_reg[$past(acc_idx)] == $past(avs_writedata[SEL_W-1:0]))
    else $error("unlocked input select write not stored");

  AST_BANKS_APART: assert property ( // RULE1
    out_wr |=> $stable(in_sel_reg))
    else $error("output select write disturbed input bank");

  AST_ONE_WAY: assert property ( // RULE12
    lock_reg && one_way_lock_option |=> lock_reg)
    else $error("lock cleared under one-way option");

  AST_GROUP_ROUTE: assert property ( // RULE5
    in_sel_reg[pin_routing_pkg::EXT_IRQ3_PIN_SEL_IDX] == 4'h2 ##1
    $stable(in_sel_reg[pin_routing_pkg::EXT_IRQ3_PIN_SEL_IDX])
    |-> ext_irq3_input == $past(remappable_pin_in[pin_routing_pkg::GROUP_PINS + 2]
                                && !remappable_pin_analog[pin_routing_pkg::GROUP_PINS + 2]))
    else $error("input routed from the wrong pin");

  AST_RESERVED_LOW: assert property ( // RULE14
    in_sel_reg[0][3] |=> !ext_irq4_input)
    else $error("reserved input code passed a pin level");

  AST_NULL_OUT: assert property ( // RULE10
    out_sel_reg[0] == pin_routing_pkg::NULL_CODE |=> !remappable_pin_oe[0])
    else $error("null output code drove a pin");

  AST_ROUTE_OUT: assert property ( // RULE9
    out_sel_reg[0] == 4'h1 && !remappable_pin_analog[0]
    |=> remappable_pin_oe[0] && remappable_pin_out[0] == $past(uart1_tx))
    else $error("pin not driven from selected source");

  AST_ANALOG_WINS: assert property ( // RULE13
    remappable_pin_analog[NUM_PINS-1] |=> !remappable_pin_oe[NUM_PINS-1])
    else $error("remapped output overrode analog pin");

  AST_READ_ZERO_TOP: assert property ( // RULE15
    bus_commit && avs_read && acc_kind inside {pin_routing_pkg::KIND_IN, pin_routing_pkg::KIND_OUT}
    |-> avs_readdata_reg[pin_routing_pkg::DATA_W-1:SEL_W] == '0)
    else $error("select readback upper bits not zero");

  COV_UNLOCKED_WRITE: cover property (in_wr && !lock_reg);
  COV_ONE_WAY_LOCK: cover property (lock_reg && one_way_lock_option && ctrl_wr);
  COV_PIN_DRIVEN: cover property (remappable_pin_oe[0] && remappable_pin_out[0]);
  COV_INPUT_HIGH: cover property (uart1_receive_input);

endmodule

`default_nettype wire

// *** pad_periph_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// Pads and peripheral sources, moving once per cycle
module pad_periph_model (
  // Clock
  input wire logic clk,
  // Random patterns from the bench
  input wire logic [31:0] pat_a,
  input wire logic [31:0] pat_b,
  // Pad and peripheral levels
  output logic [31:0] pin_in,
  output logic [31:0] pin_analog,
  output logic [16:0] periph_out
);
  // Sparse analog mask so that most pins stay digital
  always_ff @(posedge clk) begin
    pin_in <= pat_a;
    pin_analog <= pat_a & pat_b & {pat_b[0], pat_b[31:1]};
    periph_out <= pat_b[16:0];
  end
endmodule

`default_nettype wire

// *** remappable_pin_select_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module remappable_pin_select_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic one_way_lock_option = 1'b0;
  logic lock_m = 1'b0;
  logic [31:0] avs_writedata = 32'h0, pat_a = 32'h0, pat_b = 32'h0;
  logic [31:0] avs_readdata, pin_in, pin_an, pin_out, pin_oe, exp_out = 32'h0, exp_oe = 32'h0;
  logic avs_waitrequest, routing_lock_bit;
  logic [16:0] p;
  logic [23:0] pi, exp_pi = 24'h0;
  logic [3:0] in_m [24];
  logic [3:0] out_m [32];
  logic [3:0] c;
  logic [7:0] src [4];
  logic [7:0] m;
  logic [9:0] a;
  logic [31:0] d;
  integer seed = 32'h20a4;
  int bad_count = 0, check_count = 0, cyc = 0, g, k;

  always #50 clk = ~clk;

  pad_periph_model pm_u (.clk(clk), .pat_a(pat_a), .pat_b(pat_b), .pin_in(pin_in),
    .pin_analog(pin_an), .periph_out(p));

  remappable_pin_select dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .one_way_lock_option(one_way_lock_option), .routing_lock_bit(routing_lock_bit),
    .remappable_pin_in(pin_in), .remappable_pin_analog(pin_an),
    .remappable_pin_out(pin_out), .remappable_pin_oe(pin_oe),
    .uart1_tx(p[0]), .uart2_rts(p[1]), .spi1_select_out(p[2]), .compare1_out(p[3]),
    .comparator2_out(p[4]), .spi1_data_out(p[5]), .spi2_data_out(p[6]), .compare2_out(p[7]),
    .comparator3_out(p[8]), .compare4_out(p[9]), .compare5_out(p[10]), .ref_clock_out(p[11]),
    .uart1_rts(p[12]), .uart2_tx(p[13]), .spi2_select_out(p[14]), .compare3_out(p[15]),
    .comparator1_out(p[16]), .ext_irq4_input(pi[0]), .timer2_clock_input(pi[1]),
    .capture4_input(pi[2]), .spi1_slave_select_input(pi[3]), .reference_clock_input(pi[4]),
    .ext_irq3_input(pi[5]), .timer3_clock_input(pi[6]), .capture3_input(pi[7]),
    .uart1_clear_to_send_input(pi[8]), .uart2_receive_input(pi[9]), .spi1_data_input(pi[10]),
    .ext_irq2_input(pi[11]), .timer4_clock_input(pi[12]), .capture1_input(pi[13]),
    .capture5_input(pi[14]), .uart1_receive_input(pi[15]), .uart2_clear_to_send_input(pi[16]),
    .spi2_data_input(pi[17]), .compare_fault_b_input(pi[18]), .ext_irq1_input(pi[19]),
    .timer5_clock_input(pi[20]), .capture2_input(pi[21]), .spi2_slave_select_input(pi[22]),
    .compare_fault_a_input(pi[23]));

  ////////////////////////////////////////////////////////////////////////////////
  // Reference model; routing uses pre-edge selects, lock shows its new value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      foreach (in_m[i]) in_m[i] = 4'h0;
      foreach (out_m[i]) out_m[i] = 4'h0;
      lock_m = 1'b0;
      exp_pi = 24'h0;
      exp_out = 32'h0;
      exp_oe = 32'h0;
    end else begin
      src[0] = {p[4], 1'b0, p[3], 1'b0, p[2], p[1], p[0], 1'b0};
      src[1] = {p[8], 1'b0, p[7], p[6], p[5], 3'h0};
      src[2] = {p[11], p[10], p[9], p[6], p[5], 3'h0};
      src[3] = {p[16], 1'b0, p[15], p[14], 1'b0, p[13], p[12], 1'b0};
      for (int i = 0; i < 24; i++) begin
        g = (i >= 19) ? 3 : (i >= 11) ? 2 : (i >= 5) ? 1 : 0;
        c = in_m[i];
        exp_pi[i] = !c[3] && pin_in[g*8+c[2:0]] && !pin_an[g*8+c[2:0]];
      end
      for (int q = 0; q < 32; q++) begin
        g = q / 8;
        c = out_m[q];
        m = (g == 0) ? pin_routing_pkg::OUT_CODE_VALID_A : (g == 1) ?
          pin_routing_pkg::OUT_CODE_VALID_B : (g == 2) ? pin_routing_pkg::OUT_CODE_VALID_C :
          pin_routing_pkg::OUT_CODE_VALID_D;
        exp_oe[q] = !c[3] && m[c[2:0]] && !pin_an[q];
        // Level follows the source whenever the code is valid; analog only drops the enable
        exp_out[q] = !c[3] && m[c[2:0]] && src[g][c[2:0]];
      end
      // Locked select writes finish but change nothing
      if (avs_write && !avs_waitrequest && avs_address[1:0] == 2'b00) begin
        if (avs_address < 10'h060 && !lock_m) in_m[avs_address[6:2]] = avs_writedata[3:0];
        else if (avs_address >= 10'h100 && avs_address < 10'h180 && !lock_m)
          out_m[avs_address[6:2]] = avs_writedata[3:0];
        else if (avs_address == 10'h200 && avs_writedata[13]) lock_m = 1'b1;
        else if (avs_address == 10'h200 && !one_way_lock_option) lock_m = 1'b0;
      end
    end
  end

  // Settled outputs checked mid-cycle
  always @(negedge clk) begin
    chk({40'h0, pi}, {40'h0, exp_pi});
    chk({63'h0, routing_lock_bit}, {63'h0, lock_m});
    chk({pin_oe, pin_out}, {exp_oe, exp_out});
  end

  // Random pad traffic and the hang limit
  always @(posedge clk) begin
    pat_a <= $random(seed);
    pat_b <= $random(seed);
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  function automatic logic [31:0] rd(input logic [9:0] ad);
    if (ad[1:0] != 2'b00) return 32'h0;
    if (ad < 10'h060) return {28'h0, in_m[ad[6:2]]};
    if (ad >= 10'h100 && ad < 10'h180) return {28'h0, out_m[ad[6:2]]};
    if (ad == 10'h200) return {2'h0, one_way_lock_option, 15'h0, lock_m, 13'h0};
    return 32'h0;
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) bad_count++;
    if (!wr) chk({32'h0, avs_readdata}, {32'h0, rd(ad)});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, random map traffic, lock modes, second reset
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 32; i++) bus(1'b0, 10'(10'h100 + 4 * i), 32'h0);
    repeat (300) begin
      k = int'($unsigned($random(seed)) % 58);
      a = (k < 24) ? 10'(4 * k) : (k < 56) ? 10'(10'h100 + 4 * (k - 24)) :
        (k == 56) ? 10'h3fc : 10'h005;
      d = $random(seed);
      bus(1'b1, a, d);
      bus(1'b0, a, 32'h0);
    end
    bus(1'b1, 10'h200, 32'h0000_2000);
    bus(1'b1, 10'h000, 32'h0000_0005);
    bus(1'b0, 10'h000, 32'h0);
    bus(1'b1, 10'h200, 32'h0);
    bus(1'b1, 10'h014, 32'h0000_0002);
    bus(1'b1, 10'h100, 32'h0000_0001);
    bus(1'b1, 10'h000, 32'h0000_0005);
    bus(1'b0, 10'h000, 32'h0);
    one_way_lock_option <= 1'b1;
    bus(1'b1, 10'h200, 32'h0000_2000);
    bus(1'b1, 10'h200, 32'h0);
    bus(1'b1, 10'h104, 32'h0000_0001);
    bus(1'b0, 10'h200, 32'h0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 10'h200, 32'h0);
    bus(1'b0, 10'h104, 32'h0);
    results();
  end
endmodule

`default_nettype wire
